// *** rtl/fsreg_pkg.sv ***
// Notes on behaviour
// - status one bits 4..0 show per-string open/short fault, string order
// - status two bit 2 is 1 while the rectifier diode is missing
// - status two bit 1 latches thermal shutdown until that register is read
// - ident one returns a fixed two-digit bcd die code
// - ident two returns variant bcd digit high, mask revision low
package fsreg_pkg;
    localparam logic [7:0] FSREG_ADDR_STRING_FAULT = 8'h2d;
    localparam logic [7:0] FSREG_ADDR_PROT_EVENT = 8'h2e;
    localparam logic [7:0] FSREG_ADDR_DIE_IDENT = 8'h39;
    localparam logic [7:0] FSREG_ADDR_VAR_IDENT = 8'h3a;
    localparam int FSREG_STRINGS = 5;
    localparam int FSREG_BIT_DIODE = 2;
    localparam int FSREG_BIT_THERMAL = 1;
    localparam int FSREG_BIT_OVERV = 0;
    // identity codes: values arbitrary
    localparam logic [3:0] FSREG_DIE_HI = 4'h1;
    localparam logic [3:0] FSREG_DIE_LO = 4'h2;
    localparam logic [3:0] FSREG_VARIANT = 4'h3;
    localparam logic [3:0] FSREG_MASK_REV = 4'h4;
    localparam logic [7:0] FSREG_RDATA_RESET = 8'h00;
    localparam logic FSREG_LATCH_RESET = 1'b0;

    typedef struct packed {
        logic [FSREG_STRINGS-1:0] string_fault;
        logic diode_absent;
        logic thermal_event;
        logic overvoltage_event;
    } fsreg_det_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsreg_req_t;
endpackage

// *** rtl/fsreg_event_latch.sv ***
`timescale 1ns/1ns
module fsreg_event_latch
    import fsreg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic event_i,
    input wire logic clear_i,
    output logic latch_o
);
    logic latch_q;
    logic latch_d;

    // set wins over a clear in the same cycle
    assign latch_d = event_i | (latch_q & ~clear_i);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            latch_q <= FSREG_LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    assign latch_o = latch_q;

    set_wins_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        event_i |=> latch_q)
        else $error("event lost in latch");
endmodule

// *** rtl/fsreg_top.sv ***
`timescale 1ns/1ns
module fsreg_top
    import fsreg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire fsreg_det_t det_i,
    input wire fsreg_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o
);
    // latched event state
    logic thermal_q;
    logic overv_q;

    // read path registers
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // address decode
    logic hit_fault;
    logic hit_prot;
    logic hit_die;
    logic hit_var;
    logic hit_none;
    logic prot_read;

    // register images
    logic [7:0] fault_word;
    logic [7:0] prot_word;
    logic [7:0] die_word;
    logic [7:0] var_word;

    assign hit_fault = req_i.addr == FSREG_ADDR_STRING_FAULT;
    assign hit_prot = req_i.addr == FSREG_ADDR_PROT_EVENT;
    assign hit_die = req_i.addr == FSREG_ADDR_DIE_IDENT;
    assign hit_var = req_i.addr == FSREG_ADDR_VAR_IDENT;
    assign hit_none = ~(hit_fault | hit_prot | hit_die | hit_var);
    assign prot_read = req_i.rd & hit_prot;
    assign rvalid_d = req_i.rd;

    // event latches, set wins over clear
    fsreg_event_latch u_thermal (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(det_i.thermal_event),
        .clear_i(prot_read),
        .latch_o(thermal_q)
    );

    fsreg_event_latch u_overv (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(det_i.overvoltage_event),
        .clear_i(prot_read),
        .latch_o(overv_q)
    );

    // per-string fault bits in string order
    genvar g;
    generate
        for (g = 0; g < FSREG_STRINGS; g++) begin : g_fault
            assign fault_word[g] = det_i.string_fault[g];
        end
    endgenerate
    assign fault_word[7:FSREG_STRINGS] = '0;

    always_comb begin
        prot_word = 8'h00;
        prot_word[FSREG_BIT_DIODE] = det_i.diode_absent;
        prot_word[FSREG_BIT_THERMAL] = thermal_q;
        prot_word[FSREG_BIT_OVERV] = overv_q;
    end

    // fixed identity words
    assign die_word = {FSREG_DIE_HI, FSREG_DIE_LO};
    assign var_word = {FSREG_VARIANT, FSREG_MASK_REV};

    // writes are ignored everywhere
    always_comb begin
        if (!req_i.rd) begin
            rdata_d = rdata_q;
        end else if (hit_fault) begin
            rdata_d = fault_word;
        end else if (hit_prot) begin
            rdata_d = prot_word;
        end else if (hit_die) begin
            rdata_d = die_word;
        end else if (hit_var) begin
            rdata_d = var_word;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // read data and strobe registers
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rdata_q <= FSREG_RDATA_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;

    // read path checks
    fault_map_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_fault |=> rdata_o == {3'b000, $past(det_i.string_fault)})
        else $error("string fault word wrong");

    fault_reserved_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_fault |=> rdata_o[7:5] == 3'b000)
        else $error("fault reserved bits nonzero");

    diode_bit_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_prot |=> rdata_o[2] == $past(det_i.diode_absent))
        else $error("diode bit wrong");

    reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_prot |=> rdata_o[7:3] == 5'h00)
        else $error("reserved bits nonzero");

    prot_old_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_prot |=> rdata_o[1:0] == $past({thermal_q, overv_q}))
        else $error("event bits not pre-clear state");

    die_ident_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_die |=> rdata_o == {FSREG_DIE_HI, FSREG_DIE_LO})
        else $error("die ident wrong");

    var_ident_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_var |=> rdata_o == {FSREG_VARIANT, FSREG_MASK_REV})
        else $error("variant ident wrong");

    unmapped_zero_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd && hit_none |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    rvalid_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.rd |=> rvalid_o)
        else $error("read strobe not answered");

    rvalid_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !req_i.rd |=> !rvalid_o)
        else $error("strobe without read");

    write_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data moved without read");

    write_ignored_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.wr && !req_i.rd |=> $stable(rdata_o))
        else $error("write changed read data");

    rdata_only_read_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $changed(rdata_o) |-> $past(req_i.rd))
        else $error("read data changed with no read");

    // event latch checks
    thermal_set_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        det_i.thermal_event |=> thermal_q)
        else $error("thermal event not latched");

    thermal_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        thermal_q && !prot_read |=> thermal_q)
        else $error("thermal latch lost");

    thermal_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        prot_read && !det_i.thermal_event |=> !thermal_q)
        else $error("thermal latch not cleared");

    thermal_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !thermal_q && !det_i.thermal_event |=> !thermal_q)
        else $error("thermal latch set with no event");

    thermal_show_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        det_i.thermal_event ##1 (req_i.rd && hit_prot) |=> rdata_o[1])
        else $error("thermal event not reported");

    overv_set_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        det_i.overvoltage_event |=> overv_q)
        else $error("overvoltage event not latched");

    overv_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        overv_q && !prot_read |=> overv_q)
        else $error("overvoltage latch lost");

    overv_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        prot_read && !det_i.overvoltage_event |=> !overv_q)
        else $error("overvoltage latch not cleared");

    overv_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !overv_q && !det_i.overvoltage_event |=> !overv_q)
        else $error("overvoltage latch set with no event");

    overv_show_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        det_i.overvoltage_event ##1 (req_i.rd && hit_prot) |=> rdata_o[0])
        else $error("overvoltage event not reported");

    // reset values
    reset_rdata_a: assert property (@(posedge clk_sys_i)
        !resetn_i |=> rdata_o == FSREG_RDATA_RESET && !rvalid_o)
        else $error("read outputs not cleared by reset");

    reset_latch_a: assert property (@(posedge clk_sys_i)
        !resetn_i |=> !thermal_q && !overv_q)
        else $error("event latches not cleared by reset");

    // scenario covers
    read_fault_c: cover property (@(posedge clk_sys_i) req_i.rd && hit_fault);
    thermal_read_c: cover property (@(posedge clk_sys_i) prot_read && thermal_q);
    set_clear_c: cover property (@(posedge clk_sys_i)
        prot_read && det_i.overvoltage_event);
    read_ident_c: cover property (@(posedge clk_sys_i) req_i.rd && hit_var);
    write_prot_c: cover property (@(posedge clk_sys_i) req_i.wr && hit_prot);
endmodule

// *** bench/fsreg_host_model.sv ***
`timescale 1ns/1ns
module fsreg_host_model
    import fsreg_pkg::*;
(
    input wire logic clk_sys_i,
    output fsreg_req_t req_o
);
    initial req_o = '0;
    // one access strobe, held for exactly one taking edge
    task automatic access(input logic [7:0] a, input logic w);
        @(posedge clk_sys_i);
        #2;
        req_o = '{rd: ~w, wr: w, addr: a, wdata: 8'hff};
        @(posedge clk_sys_i);
        #2;
        req_o = '0;
    endtask
endmodule

// *** bench/fsreg_tb_top.sv ***
`timescale 1ns/1ns
module fsreg_tb_top;
    import fsreg_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    fsreg_det_t det = '0;
    fsreg_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    int bad_count = 0;
    int n_compared = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    fsreg_top fsreg_top_inst(.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .det_i(det), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid));
    fsreg_host_model fsreg_host_model_inst(.clk_sys_i(clk_sys_i),
        .req_o(req));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        fsreg_host_model_inst.access(a, 1'b0);
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a);
        fsreg_host_model_inst.access(a, 1'b1);
        check({7'h00, rvalid}, 8'h00);
    endtask
    task automatic pulse_event;
        @(posedge clk_sys_i);
        #2;
        det.thermal_event = 1'b0;
        det.overvoltage_event = 1'b0;
    endtask
    task automatic test_ident;
        rd(FSREG_ADDR_DIE_IDENT, {FSREG_DIE_HI, FSREG_DIE_LO});
        rd(FSREG_ADDR_VAR_IDENT, {FSREG_VARIANT, FSREG_MASK_REV});
        $display("ident test done");
    endtask
    task automatic test_strings;
        for (int i = 0; i < FSREG_STRINGS; i++) begin
            det.string_fault = 5'(1 << i);
            rd(FSREG_ADDR_STRING_FAULT, 8'(1 << i));
        end
        det.string_fault = 5'h1f;
        rd(FSREG_ADDR_STRING_FAULT, 8'h1f);
        det.string_fault = 5'h00;
        $display("string test done");
    endtask
    task automatic test_events;
        det.diode_absent = 1'b1;
        det.thermal_event = 1'b1;
        pulse_event();
        rd(FSREG_ADDR_PROT_EVENT, 8'h06);
        rd(FSREG_ADDR_PROT_EVENT, 8'h04);
        det.diode_absent = 1'b0;
        det.overvoltage_event = 1'b1;
        pulse_event();
        rd(FSREG_ADDR_PROT_EVENT, 8'h01);
        rd(FSREG_ADDR_PROT_EVENT, 8'h00);
        $display("event test done");
    endtask
    task automatic test_set_wins;
        fork
            rd(FSREG_ADDR_PROT_EVENT, 8'h00);
            begin
                @(posedge clk_sys_i);
                #2;
                det.thermal_event = 1'b1;
                pulse_event();
            end
        join
        wr(FSREG_ADDR_PROT_EVENT);
        rd(FSREG_ADDR_PROT_EVENT, 8'h02);
        rd(FSREG_ADDR_PROT_EVENT, 8'h00);
        $display("set wins test done");
    endtask
    task automatic test_writes;
        wr(FSREG_ADDR_STRING_FAULT);
        rd(FSREG_ADDR_STRING_FAULT, 8'h00);
        wr(FSREG_ADDR_DIE_IDENT);
        rd(FSREG_ADDR_DIE_IDENT, {FSREG_DIE_HI, FSREG_DIE_LO});
        rd(8'h00, 8'h00);
        $display("write test done");
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #2;
        check(rdata, FSREG_RDATA_RESET);
        resetn_i = 1'b1;
        test_ident();
        test_strings();
        test_events();
        test_set_wins();
        test_writes();
        conclude();
    end
endmodule
